// ---- common/lec_defs.vh ----
/*
 * Constants for the link enhancement control block: register offsets,
 * field positions, reset values and threshold encodings.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LEC_DEFS_VH
`define LEC_DEFS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define LEC_OFF_VID_SET 12'ha80
`define LEC_OFF_VID_CLR 12'ha84
`define LEC_OFF_LNK_SET 12'ha88
`define LEC_OFF_LNK_CLR 12'ha8c

// ------------------------------------------------------------
// Video enhancement field positions and writable mask
// ------------------------------------------------------------
`define LEC_VID_STRIP0 0
`define LEC_VID_SYNC0 1
`define LEC_VID_STRIP1 4
`define LEC_VID_SYNC1 5
`define LEC_VID_MASK 32'h00000033
`define LEC_VID_RESET 32'h00000000

// ------------------------------------------------------------
// Link enhancement field positions, mask and reset
// ------------------------------------------------------------
`define LEC_LNK_PIPE_DIS 15
`define LEC_LNK_RSVD14 14
`define LEC_LNK_THR_HI 13
`define LEC_LNK_THR_LO 12
`define LEC_LNK_MASK 32'h0000f000
`define LEC_LNK_RESET 32'h00001000

// ------------------------------------------------------------
// Threshold encodings and byte counts
// ------------------------------------------------------------
`define LEC_THR_2K 2'h0
`define LEC_THR_1K7 2'h1
`define LEC_THR_1K 2'h2
`define LEC_THR_512 2'h3
`define LEC_BYTES_2K 12'h800
`define LEC_BYTES_1K7 12'h6cc
`define LEC_BYTES_1K 12'h400
`define LEC_BYTES_512 12'h200
`define LEC_QUAD_BYTES 12'h004

// ------------------------------------------------------------
// Receive framing and transmit FIFO size
// ------------------------------------------------------------
`define LEC_STRIP_QUADS 2'h2
`define LEC_FRAME_QUAD 2'h2
`define LEC_FRAME_B0 8'h1f
`define LEC_FRAME_B1_LO 4'h7
`define LEC_BRANCH_SYNC 2'h1
`define LEC_FIFO_DEPTH 16
`define LEC_FIFO_AW 4

`endif

// ---- hdl/lec_fifo.v ----
/*
 * Synchronous flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock, active-low async reset and a clock enable.
 */
`timescale 1ns/100ps
module lec_fifo #(
    parameter WIDTH = 33,
    parameter DEPTH = 16,
    parameter AW = 4
)(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign level = count;
    always @(posedge clk)
    begin
        if (ce && push)
            mem[wr_ptr] <= in_data;
    end
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else if (ce)
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ---- hdl/lec_ctrl.v ----
/*
 * Link enhancement control: set/clear register ports, receive strip and
 * video frame sync for contexts 0/1, async transmit threshold gating
 * through a 16-word FIFO with store-and-forward retry fallback.
 * Assumes a simple synchronous register port and quadlet streams.
 */
// Functional notes
// - Ctx0 strips two quadlets unless header kept
// - Ctx1 strips two quadlets unless header kept
// - Ctx0 sync waits frame start, jumps misplaced
// - Video register bits 3:2 read zero
// - Link register reached via set/clear ports
// - EEPROM loads chosen bits when present
// - Bit 15 disables async pipelining, resets 0
// - Threshold field selects 2K/1.7K/1K/512
// - After underrun retry uses store-and-forward
// - Start at threshold or whole packet
// - Underrun errors packet, retry holds whole
// - Link register bits 31:16 read zero
// - Frame start is 1fx7 at third quadlet
// - Zero retry register forces store-and-forward
`timescale 1ns/100ps
`include "lec_defs.vh"
module lec_ctrl #(
    parameter FIFO_DEPTH = `LEC_FIFO_DEPTH,
    parameter FIFO_AW = `LEC_FIFO_AW
)(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire reg_wr,
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire eeprom_valid,
    input wire [31:0] eeprom_data,
    input wire [1:0] keep_packet_header,
    input wire [1:0] rx_start,
    input wire [1:0] rx_valid,
    input wire [63:0] rx_quad,
    input wire [1:0] rx_last,
    input wire [3:0] rx_branch,
    output reg [1:0] rx_out_valid,
    output reg [63:0] rx_out_quad,
    output reg [1:0] frame_jump_pointer,
    input wire [3:0] async_retry_limit,
    input wire tx_in_valid,
    input wire [31:0] tx_in_data,
    input wire tx_in_last,
    output reg tx_in_ready,
    input wire tx_link_ready,
    output reg tx_out_valid,
    output reg [31:0] tx_out_data,
    output reg tx_out_last,
    output reg tx_underrun,
    output reg tx_retry_saf,
    output reg async_tx_pipe_disable
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [11:0] thr_bytes;
        input [1:0] sel;
        begin
            case (sel)
                `LEC_THR_1K7: thr_bytes = `LEC_BYTES_1K7;
                `LEC_THR_1K: thr_bytes = `LEC_BYTES_1K;
                `LEC_THR_512: thr_bytes = `LEC_BYTES_512;
                default: thr_bytes = `LEC_BYTES_2K;
            endcase
        end
    endfunction

    function [31:0] set_clr;
        input [31:0] cur;
        input [31:0] wd;
        input [31:0] mask;
        input is_set;
        begin
            if (is_set)
                set_clr = (cur | wd) & mask;
            else
                set_clr = cur & ~wd & mask;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [31:0] vid_reg;
    reg [31:0] lnk_reg;
    reg eeprom_done;
    wire [1:0] thr_sel;
    assign thr_sel = lnk_reg[`LEC_LNK_THR_HI:`LEC_LNK_THR_LO];

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vid_reg <= `LEC_VID_RESET;
            lnk_reg <= `LEC_LNK_RESET;
            eeprom_done <= 1'b0;
            reg_rdata <= 32'h00000000;
            async_tx_pipe_disable <= 1'b0;
        end
        else if (ce)
        begin
            // EEPROM image taken once; software writes override later
            if (eeprom_valid && !eeprom_done)
            begin
                lnk_reg <= eeprom_data & `LEC_LNK_MASK;
                eeprom_done <= 1'b1;
            end
            else if (reg_wr)
            begin
                if (reg_addr == `LEC_OFF_LNK_SET)
                    lnk_reg <= set_clr(lnk_reg, reg_wdata,
                        `LEC_LNK_MASK, 1'b1);
                else if (reg_addr == `LEC_OFF_LNK_CLR)
                    lnk_reg <= set_clr(lnk_reg, reg_wdata,
                        `LEC_LNK_MASK, 1'b0);
                else if (reg_addr == `LEC_OFF_VID_SET)
                    vid_reg <= set_clr(vid_reg, reg_wdata,
                        `LEC_VID_MASK, 1'b1);
                else if (reg_addr == `LEC_OFF_VID_CLR)
                    vid_reg <= set_clr(vid_reg, reg_wdata,
                        `LEC_VID_MASK, 1'b0);
            end
            if (reg_rd)
            begin
                if (reg_addr == `LEC_OFF_LNK_SET ||
                    reg_addr == `LEC_OFF_LNK_CLR)
                    reg_rdata <= lnk_reg & `LEC_LNK_MASK;
                else if (reg_addr == `LEC_OFF_VID_SET ||
                    reg_addr == `LEC_OFF_VID_CLR)
                    reg_rdata <= vid_reg & `LEC_VID_MASK;
                else
                    reg_rdata <= 32'h00000000;
            end
            async_tx_pipe_disable <= lnk_reg[`LEC_LNK_PIPE_DIS];
        end
    end

    // ------------------------------------------------------------
    // Receive contexts: strip and frame sync
    // ------------------------------------------------------------
    reg [1:0] quad_idx [0:1];
    reg [1:0] waiting;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : rx_ctx
            wire strip_en;
            wire sync_en;
            wire [31:0] q;
            wire is_frame;
            assign strip_en = vid_reg[4*g] && !keep_packet_header[g];
            assign sync_en = strip_en && vid_reg[4*g+1] &&
                (rx_branch[2*g+1:2*g] == `LEC_BRANCH_SYNC);
            assign q = rx_quad[32*g+31:32*g];
            // Frame tag: first byte 1f, low nibble of second byte 7
            assign is_frame = (quad_idx[g] == `LEC_FRAME_QUAD) &&
                (q[31:24] == `LEC_FRAME_B0) &&
                (q[19:16] == `LEC_FRAME_B1_LO);
            always @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    quad_idx[g] <= 2'h0;
                    waiting[g] <= 1'b1;
                    rx_out_valid[g] <= 1'b0;
                    rx_out_quad[32*g+31:32*g] <= 32'h00000000;
                    frame_jump_pointer[g] <= 1'b0;
                end
                else if (ce)
                begin
                    rx_out_valid[g] <= 1'b0;
                    frame_jump_pointer[g] <= 1'b0;
                    if (rx_valid[g])
                    begin
                        if (rx_last[g])
                            quad_idx[g] <= 2'h0;
                        else if (rx_start[g])
                            quad_idx[g] <= 2'h1;
                        else if (quad_idx[g] != 2'h3)
                            quad_idx[g] <= quad_idx[g] + 2'h1;
                        // Stay in sync: the misplaced tag opens a frame
                        if (sync_en && is_frame && !waiting[g] &&
                            !rx_start[g])
                            frame_jump_pointer[g] <= 1'b1;
                        else if (sync_en && is_frame)
                            waiting[g] <= 1'b0;
                        // Strip quads 0 and 1 of each packet
                        if (!(strip_en && quad_idx[g] <
                            `LEC_STRIP_QUADS && !rx_start[g]) &&
                            !(strip_en && rx_start[g]) &&
                            !(sync_en && waiting[g] && !is_frame))
                        begin
                            rx_out_valid[g] <= 1'b1;
                            rx_out_quad[32*g+31:32*g] <= q;
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Async transmit: threshold gating over the FIFO
    // ------------------------------------------------------------
    wire [32:0] fo_data;
    wire fo_valid;
    wire fi_ready;
    reg [11:0] buffered;
    reg have_last;
    reg sending;
    reg saf_mode;
    wire fo_ready;
    wire [11:0] thr_now;
    wire start_ok;
    assign thr_now = (saf_mode || async_retry_limit == 4'h0) ?
        `LEC_BYTES_2K : thr_bytes(thr_sel);
    // A 16-word FIFO holds far less than any threshold, so full counts
    // as reached; store-and-forward of a longer packet stalls
    assign start_ok = have_last || (!saf_mode &&
        async_retry_limit != 4'h0 && thr_sel != `LEC_THR_2K &&
        (buffered >= thr_now || !fi_ready));
    assign fo_ready = sending && tx_link_ready;

    lec_fifo #(
        .WIDTH(33),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) i_lec_fifo (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .in_data({tx_in_last, tx_in_data}),
        .in_valid(tx_in_valid),
        .in_ready(fi_ready),
        .out_data(fo_data),
        .out_valid(fo_valid),
        .out_ready(fo_ready),
        .level()
    );

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buffered <= 12'h000;
            have_last <= 1'b0;
            sending <= 1'b0;
            saf_mode <= 1'b0;
            tx_in_ready <= 1'b0;
            tx_out_valid <= 1'b0;
            tx_out_data <= 32'h00000000;
            tx_out_last <= 1'b0;
            tx_underrun <= 1'b0;
            tx_retry_saf <= 1'b0;
        end
        else if (ce)
        begin
            tx_in_ready <= fi_ready;
            tx_out_valid <= fo_valid && fo_ready;
            tx_out_data <= fo_data[31:0];
            tx_out_last <= fo_valid && fo_ready && fo_data[32];
            tx_underrun <= 1'b0;
            tx_retry_saf <= saf_mode;
            if (tx_in_valid && fi_ready)
            begin
                if (buffered != `LEC_BYTES_2K)
                    buffered <= buffered + `LEC_QUAD_BYTES;
                if (tx_in_last)
                    have_last <= 1'b1;
            end
            if (!sending && start_ok && fo_valid)
                sending <= 1'b1;
            if (fo_valid && fo_ready && fo_data[32])
            begin
                // The next packet may push in this very cycle; keep it
                sending <= 1'b0;
                have_last <= tx_in_valid && fi_ready && tx_in_last;
                buffered <= (tx_in_valid && fi_ready) ?
                    `LEC_QUAD_BYTES : 12'h000;
                saf_mode <= 1'b0;
            end
            else if (sending && !fo_valid && !have_last)
            begin
                // FIFO ran dry mid packet: errored, retry whole
                tx_underrun <= 1'b1;
                sending <= 1'b0;
                saf_mode <= 1'b1;
            end
        end
    end
endmodule

// ---- dv/lec_ctrl_checker.sv ----
/* Port checker for lec_ctrl.
   Assumes binding to every lec_ctrl instance, one clock domain. */
`timescale 1ns/100ps
module lec_ctrl_checker (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire reg_wr,
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire eeprom_valid,
    input wire [1:0] keep_packet_header,
    input wire [1:0] rx_valid,
    input wire [63:0] rx_quad,
    input wire [1:0] rx_out_valid,
    input wire [63:0] rx_out_quad,
    input wire tx_underrun,
    input wire tx_retry_saf,
    input wire async_tx_pipe_disable
);
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
// Writes are dropped in the eeprom load cycle, so leave those out
wire wr_ok = ce && reg_wr && !eeprom_valid;
wire rd_ok = ce && reg_rd;
a_pipe_set_seen: assert property (wr_ok && reg_addr == 12'ha88 &&
    reg_wdata[15] |-> ##2 async_tx_pipe_disable) else $error("no set");
a_pipe_clear_seen: assert property (wr_ok && reg_addr == 12'ha8c &&
    reg_wdata[15] |-> ##2 !async_tx_pipe_disable) else $error("no clear");
a_link_upper_zero: assert property (rd_ok && reg_addr[11:3] == 9'h151
    |=> reg_rdata[31:16] == 16'h0000) else $error("upper bits set");
a_video_rsvd_zero: assert property (rd_ok && reg_addr[11:3] == 9'h150
    |=> reg_rdata[3:2] == 2'h0) else $error("video bits 3:2 set");
a_unmapped_reads_zero: assert property (rd_ok && reg_addr[11:4] != 8'ha8
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
a_keep_hdr0: assert property (ce && keep_packet_header[0] && rx_valid[0]
    |=> rx_out_valid[0] && rx_out_quad[31:0] == $past(rx_quad[31:0]))
    else $error("ctx0 quad lost");
a_keep_hdr1: assert property (ce && keep_packet_header[1] && rx_valid[1]
    |=> rx_out_valid[1] && rx_out_quad[63:32] == $past(rx_quad[63:32]))
    else $error("ctx1 quad lost");
a_rx_idle_quiet: assert property (ce && !rx_valid[0] |=> !rx_out_valid[0])
    else $error("ctx0 output without input");
a_underrun_one_cycle: assert property (tx_underrun |=> !tx_underrun)
    else $error("underrun pulse too long");
a_retry_saf_follows: assert property (tx_underrun |-> ##[0:1] tx_retry_saf)
    else $error("no store-and-forward after underrun");
endmodule
bind lec_ctrl lec_ctrl_checker i_lec_ctrl_checker (.clk, .resetn, .ce,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .eeprom_valid,
    .keep_packet_header, .rx_valid, .rx_quad, .rx_out_valid, .rx_out_quad,
    .tx_underrun, .tx_retry_saf, .async_tx_pipe_disable);

// ---- dv/lec_ctrl_test.sv ----
/* Testbench for lec_ctrl: register ports, receive strip and sync,
   transmit gating. Assumes the checker file is compiled alongside. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end end
module lec_ctrl_test;
// ------------------------------------------------------------
// Signals and instance
// ------------------------------------------------------------
logic clk = 0, resetn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
logic [11:0] reg_addr = 0;
logic [31:0] reg_wdata = 0, reg_rdata, eeprom_data = 0, tx_in_data = 0;
logic eeprom_valid = 0, tx_in_valid = 0, tx_in_last = 0, tx_link_ready = 0;
logic [1:0] keep_packet_header = 0, rx_start = 0, rx_valid = 0, rx_last = 0;
logic [63:0] rx_quad = 0, rx_out_quad;
logic [3:0] rx_branch = 0, async_retry_limit = 4'h3;
logic [1:0] rx_out_valid, frame_jump_pointer;
logic tx_in_ready, tx_out_valid, tx_out_last, tx_underrun, tx_retry_saf;
logic async_tx_pipe_disable, last_in = 0;
logic [31:0] tx_out_data, q0[$], q1[$], got[$];
logic [32:0] txq[$];
int fail_count = 0, n_compared = 0, cyc = 0, early = 0;
int jumps = 0, underruns = 0, saf_seen = 0;
lec_ctrl i_lec_ctrl (.clk, .resetn, .ce, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .eeprom_valid, .eeprom_data, .keep_packet_header,
    .rx_start, .rx_valid, .rx_quad, .rx_last, .rx_branch, .rx_out_valid,
    .rx_out_quad, .frame_jump_pointer, .async_retry_limit, .tx_in_valid,
    .tx_in_data, .tx_in_last, .tx_in_ready, .tx_link_ready, .tx_out_valid,
    .tx_out_data, .tx_out_last, .tx_underrun, .tx_retry_saf,
    .async_tx_pipe_disable);
initial forever #4 clk = ~clk;
// Outputs are registered, so the falling edge sees them settled
always @(negedge clk)
begin
    if (rx_out_valid[0] === 1'b1) q0.push_back(rx_out_quad[31:0]);
    if (rx_out_valid[1] === 1'b1) q1.push_back(rx_out_quad[63:32]);
    if (tx_out_valid === 1'b1) txq.push_back({tx_out_last, tx_out_data});
    if (tx_out_valid === 1'b1 && !last_in) early++;
    if (frame_jump_pointer[0] === 1'b1) jumps++;
    if (tx_underrun === 1'b1) underruns++;
    if (tx_retry_saf === 1'b1) saf_seen++;
end
always @(posedge clk)
begin
    cyc++;
    if (tx_in_valid && tx_in_last) last_in = 1;
    if (cyc == 5000)
    begin
        fail_count++;
        report_and_stop;
    end
end
// ------------------------------------------------------------
// Bus and stream tasks
// ------------------------------------------------------------
task wr(input [11:0] a, input [31:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    reg_wr = 0;
endtask
task rdc(input [11:0] a, input [31:0] e);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk);
    reg_rd = 0;
    `CHK(reg_rdata, e)
endtask
// Four-quad packet; the tag lands in quad 2 when asked
task send_pkt(input int g, input bit tag);
    for (int k = 0; k < 4; k++)
    begin
        @(negedge clk);
        {rx_valid[g], rx_start[g], rx_last[g]} = {1'b1, k == 0, k == 3};
        rx_quad[32*g +: 32] = (tag && k == 2) ? 32'h1f070000 : 32'ha0 + k;
    end
    @(negedge clk);
    rx_valid = 2'h0;
    repeat (3) @(negedge clk);
endtask
task tx_push(input [31:0] d, input bit l);
    @(negedge clk);
    {tx_in_valid, tx_in_data, tx_in_last} = {1'b1, d, l};
    @(negedge clk);
    tx_in_valid = 0;
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task t_regs;
    rdc(12'ha88, 32'h00001000);
    // Link bits are set up before any traffic; bit 14 kept low
    wr(12'ha88, 32'hffffbfff);
    @(negedge clk);
    `CHK(async_tx_pipe_disable, 1'b1)
    rdc(12'ha8c, 32'h0000b000);
    wr(12'ha8c, 32'h0000c000);
    rdc(12'ha88, 32'h00003000);
    `CHK(async_tx_pipe_disable, 1'b0)
    rdc(12'h100, 32'h0);
    $display("done: registers");
endtask
task t_video;
    rdc(12'ha80, 32'h0);
    wr(12'ha80, 32'hffffffff);
    rdc(12'ha84, 32'h00000033);
    wr(12'ha84, 32'h00000033);
    rdc(12'ha80, 32'h0);
    wr(12'ha80, 32'h00000011);
    $display("done: video register");
endtask
task t_strip(input int g, input bit keep);
    keep_packet_header = {keep, keep};
    q0.delete();
    q1.delete();
    send_pkt(g, 0);
    if (g)
        got = q1;
    else
        got = q0;
    `CHK(got.size(), keep ? 4 : 2)
    `CHK(got[0], keep ? 32'ha0 : 32'ha2)
    keep_packet_header = 2'h0;
    $display("done: strip");
endtask
task t_sync;
    wr(12'ha80, 32'h00000003);
    rx_branch = 4'h1;
    q0.delete();
    jumps = 0;
    send_pkt(0, 0);
    `CHK(q0.size(), 0)
    send_pkt(0, 1);
    `CHK(q0.size(), 2)
    `CHK(q0[0], 32'h1f070000)
    `CHK(jumps, 0)
    send_pkt(0, 1);
    `CHK(jumps, 1)
    `CHK(q0.size(), 4)
    $display("done: frame sync");
endtask
// Packet fits the FIFO, so sending starts only once last is in
task t_tx(input [1:0] thr);
    wr(12'ha8c, 32'h00003000);
    wr(12'ha88, {18'h0, thr, 12'h0});
    rdc(12'ha88, {18'h0, thr, 12'h0});
    txq.delete();
    last_in = 0;
    early = 0;
    tx_link_ready = 1;
    for (int k = 0; k < 4; k++)
        tx_push(32'hc0 + k, k == 3);
    repeat (10) @(negedge clk);
    `CHK(early, 0)
    `CHK(txq.size(), 4)
    `CHK(txq[0], {1'b0, 32'hc0})
    `CHK(txq[3], {1'b1, 32'hc3})
    $display("done: transmit");
endtask
// Packet longer than the FIFO: a held source drains it and underruns
task t_underrun;
    wr(12'ha88, 32'h00003000);
    async_retry_limit = 4'h0;
    tx_link_ready = 1;
    last_in = 0;
    txq.delete();
    for (int k = 0; k < 16; k++)
        tx_push(32'hb00 + k, 0);
    repeat (8) @(negedge clk);
    `CHK(txq.size(), 0)
    async_retry_limit = 4'h3;
    repeat (30) @(negedge clk);
    `CHK(txq.size(), 16)
    `CHK(txq[0], {1'b0, 32'hb00})
    `CHK(underruns, 1)
    `CHK(saf_seen > 0, 1'b1)
    early = 0;
    for (int k = 0; k < 4; k++)
        tx_push(32'hd0 + k, k == 3);
    repeat (12) @(negedge clk);
    `CHK(early, 0)
    `CHK(txq.size(), 20)
    `CHK(txq[19], {1'b1, 32'hd3})
    `CHK(tx_retry_saf, 1'b0)
    $display("done: underrun");
endtask
// Clock enable low must freeze the register file
task t_ce;
    @(negedge clk);
    ce = 0;
    wr(12'ha88, 32'h00008000);
    @(negedge clk);
    ce = 1;
    rdc(12'ha88, 32'h00003000);
    `CHK(async_tx_pipe_disable, 1'b0)
    $display("done: clock enable");
endtask
task t_eeprom;
    eeprom_data = 32'hffffbfff;
    @(negedge clk);
    eeprom_valid = 1;
    @(negedge clk);
    eeprom_valid = 0;
    rdc(12'ha88, 32'h0000b000);
    $display("done: eeprom");
endtask
task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    repeat (10) @(negedge clk);
    resetn = 1;
    t_regs;
    t_video;
    t_strip(0, 0);
    t_strip(1, 0);
    t_strip(0, 1);
    t_sync;
    for (int t = 0; t < 4; t++)
        t_tx(t[1:0]);
    t_underrun;
    t_ce;
    t_eeprom;
    report_and_stop;
end
endmodule
